// [core/ras_params.svh]
// register offsets, field positions and constants of the return address stack
// assumes inclusion by bare name from design and testbench files
`ifndef RAS_PARAMS_SVH
`define RAS_PARAMS_SVH

`define RAS_ADDR_W        4
`define RAS_OFF_PTR       4'h0
`define RAS_OFF_TOS_LOW   4'h1
`define RAS_OFF_TOS_HIGH  4'h2
`define RAS_OFF_TOS_UPPER 4'h3
`define RAS_PTR_W         5
`define RAS_PC_W          21
`define RAS_DEPTH         31
`define RAS_PTR_MAX       5'h1F
`define RAS_PTR_ZERO      5'h00
`define RAS_PTR_ONE       5'h01
`define RAS_BIT_FULL      7
`define RAS_BIT_UNF       6
`define RAS_PC_STEP       21'h000002
`define RAS_PC_ZERO       21'h000000
`define RAS_BYTE_ZERO     8'h00
`define RAS_UPPER_W       5
`define RAS_LOW_MSB       7
`define RAS_HIGH_LSB      8
`define RAS_HIGH_MSB      15
`define RAS_UPPER_LSB     16
`define RAS_UPPER_MSB     20
`define RAS_PAD3_ZERO     3'h0

`endif

// [core/ras_pkg.sv]
// types shared by the return address stack files
// assumes ras_params.svh is compiled alongside
package ras_pkg;

    typedef struct packed {
        logic [7:0] status;
        logic [7:0] working;
        logic [7:0] bank;
    } core_regs_t;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_RUN   = 3'b010,
        ST_RESET = 3'b100
    } ras_state_t;

endpackage : ras_pkg

// [core/ras_shadow.sv]
// one-level shadow copy of status, working and bank-select registers
// assumes save and restore come from the sequencer as one-cycle pulses
`timescale 1ns/1ps
module ras_shadow
(
    input  wire logic               clock,
    input  wire logic               rst_n,
    input  wire logic               save,
    input  wire logic               restore,
    input  wire ras_pkg::core_regs_t live,
    output      ras_pkg::core_regs_t restore_val,
    output      logic               restore_valid
);
    ras_pkg::core_regs_t shadow_r;

    // later save simply overwrites: nested interrupts lose the old copy
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            shadow_r <= '0;
        else if (save)
            shadow_r <= live;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            restore_valid <= 1'b0;
        else
            restore_valid <= restore;
    end

    assign restore_val = shadow_r;

    property p_shadow_capture;
        @(posedge clock) disable iff (!rst_n)
        save |=> (shadow_r == $past(live));
    endproperty
    a_shadow_capture: assert property (p_shadow_capture) else $error("shadow not captured");
endmodule : ras_shadow

// [core/ras_stack_mem.sv]
// 31 x 21 return address storage, index 1..31, no cell at index zero
// assumes writes only with a nonzero index
`timescale 1ns/1ps
`include "ras_params.svh"
module ras_stack_mem
(
    input  wire logic                   clock,
    input  wire logic                   we,
    input  wire logic [`RAS_PTR_W-1:0]  waddr,
    input  wire logic [`RAS_PC_W-1:0]   wdata,
    input  wire logic [`RAS_PTR_W-1:0]  raddr,
    output      logic [`RAS_PC_W-1:0]   rdata
);
    logic [`RAS_PC_W-1:0] cells [1:`RAS_DEPTH];

    always_ff @(posedge clock)
    begin
        if (we && waddr != `RAS_PTR_ZERO)
            cells[waddr] <= wdata;
    end

    // combinational read; index zero reads as empty
    always_comb
    begin
        if (raddr == `RAS_PTR_ZERO)
            rdata = `RAS_PC_ZERO;
        else
            rdata = cells[raddr];
    end
endmodule : ras_stack_mem

// [core/return_address_stack.sv]
// return address stack with pointer/flag register and fast shadow registers
// assumes one-cycle push/pop pulses from the sequencer; pop wins if both come at once
`timescale 1ns/1ps
`include "ras_params.svh"
module return_address_stack
(
    input  wire logic                   clock,
    input  wire logic                   rst_n,
    input  wire logic                   por_n,
    input  wire logic                   overflow_reset_enable,
    input  wire logic                   push,
    input  wire logic                   pop,
    input  wire logic                   push_plus_two,
    input  wire logic [`RAS_PC_W-1:0]   program_counter,
    input  wire logic                   shadow_save,
    input  wire logic                   shadow_restore,
    input  wire ras_pkg::core_regs_t    live_regs,
    input  wire ras_pkg::reg_req_t      bus,
    output      logic [7:0]             rdata,
    output      logic [`RAS_PC_W-1:0]   pop_value,
    output      logic                   pop_valid,
    output      logic                   stack_reset_req,
    output      ras_pkg::core_regs_t    restore_regs,
    output      logic                   restore_valid
);
    logic [`RAS_PTR_W-1:0]  ptr_r;
    logic                   stack_full_flag;
    logic                   stack_underflow_flag;
    logic [`RAS_PC_W-1:0]   top_entry;
    logic                   mem_we;
    logic [`RAS_PTR_W-1:0]  mem_waddr;
    logic [`RAS_PC_W-1:0]   mem_wdata;
    logic                   reg_wr_ptr;
    logic                   do_push;
    logic                   do_pop;
    logic                   at_full;
    logic                   at_empty;
    logic                   full_event;
    logic                   unf_event;
    ras_pkg::core_regs_t    restore_val;
    ras_pkg::ras_state_t    state_r;

    assign reg_wr_ptr = bus.wr && bus.addr == `RAS_OFF_PTR;
    assign at_full    = ptr_r == `RAS_PTR_MAX;
    assign at_empty   = ptr_r == `RAS_PTR_ZERO;
    assign do_push    = push && !pop;
    assign do_pop     = pop;
    // the 31st push lands on index 31 and raises full
    assign full_event = do_push && ptr_r == (`RAS_PTR_MAX - `RAS_PTR_ONE);
    assign unf_event  = do_pop && at_empty;

    ras_stack_mem u_mem
    (
        .clock (clock),
        .we    (mem_we),
        .waddr (mem_waddr),
        .wdata (mem_wdata),
        .raddr (ptr_r),
        .rdata (top_entry)
    );

    ras_shadow u_shadow
    (
        .clock         (clock),
        .rst_n         (rst_n),
        .save          (shadow_save),
        .restore       (shadow_restore),
        .live          (live_regs),
        .restore_val   (restore_val),
        .restore_valid (restore_valid)
    );

    assign restore_regs = restore_val;

    // storage write: push into the slot above, or software top-byte write
    always_comb
    begin
        mem_we    = 1'b0;
        mem_waddr = ptr_r + `RAS_PTR_ONE;
        mem_wdata = push_plus_two ? program_counter + `RAS_PC_STEP : program_counter;
        if (do_push && !at_full)
        begin
            mem_we = 1'b1;
        end
        else if (bus.wr && !at_empty)
        begin
            mem_waddr = ptr_r;
            mem_wdata = top_entry;
            case (bus.addr)
                `RAS_OFF_TOS_LOW:
                begin
                    mem_we = 1'b1;
                    mem_wdata[`RAS_LOW_MSB:0] = bus.wdata;
                end
                `RAS_OFF_TOS_HIGH:
                begin
                    mem_we = 1'b1;
                    mem_wdata[`RAS_HIGH_MSB:`RAS_HIGH_LSB] = bus.wdata;
                end
                `RAS_OFF_TOS_UPPER:
                begin
                    mem_we = 1'b1;
                    mem_wdata[`RAS_UPPER_MSB:`RAS_UPPER_LSB] = bus.wdata[`RAS_UPPER_W-1:0];
                end
                default:
                begin
                    mem_we = 1'b0;
                end
            endcase
        end
    end

    // pointer; the overflow-triggered reset returns it to zero
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            ptr_r <= `RAS_PTR_ZERO;
        else if (state_r == ras_pkg::ST_RESET)
            ptr_r <= `RAS_PTR_ZERO;
        else if (do_push && !at_full)
            ptr_r <= ptr_r + `RAS_PTR_ONE;
        else if (do_pop && !at_empty)
            ptr_r <= ptr_r - `RAS_PTR_ONE;
        // a refused push or pop still outranks a pointer write
        else if (reg_wr_ptr && !push && !pop)
            ptr_r <= bus.wdata[`RAS_PTR_W-1:0];
    end

    // sticky flags survive device reset; power-on or a pointer write with the bit at zero clears; set beats clear
    always_ff @(posedge clock)
    begin
        if (!por_n)
        begin
            stack_full_flag      <= 1'b0;
            stack_underflow_flag <= 1'b0;
        end
        else
        begin
            if (full_event || (do_push && at_full))
                stack_full_flag <= 1'b1;
            else if (reg_wr_ptr && !bus.wdata[`RAS_BIT_FULL])
                stack_full_flag <= 1'b0;
            if (unf_event)
                stack_underflow_flag <= 1'b1;
            else if (reg_wr_ptr && !bus.wdata[`RAS_BIT_UNF])
                stack_underflow_flag <= 1'b0;
        end
    end

    // reset request sequencer: one pulse after a full or underflow event
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            state_r <= ras_pkg::ST_IDLE;
        else
        begin
            case (state_r)
                ras_pkg::ST_IDLE:
                    state_r <= ras_pkg::ST_RUN;
                ras_pkg::ST_RUN:
                    if (overflow_reset_enable && (full_event || unf_event))
                        state_r <= ras_pkg::ST_RESET;
                ras_pkg::ST_RESET:
                    state_r <= ras_pkg::ST_RUN;
                default:
                    state_r <= ras_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            stack_reset_req <= 1'b0;
        else
            stack_reset_req <= overflow_reset_enable && (full_event || unf_event);
    end

    // pop value: entry read before the decrement, zero on underflow
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            pop_value <= `RAS_PC_ZERO;
            pop_valid <= 1'b0;
        end
        else
        begin
            pop_valid <= do_pop;
            if (do_pop)
                pop_value <= top_entry;
        end
    end

    // register reads, one cycle later
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            rdata <= `RAS_BYTE_ZERO;
        else if (bus.rd)
        begin
            case (bus.addr)
                `RAS_OFF_PTR:
                    rdata <= {stack_full_flag, stack_underflow_flag, 1'b0, ptr_r};
                `RAS_OFF_TOS_LOW:
                    rdata <= top_entry[`RAS_LOW_MSB:0];
                `RAS_OFF_TOS_HIGH:
                    rdata <= top_entry[`RAS_HIGH_MSB:`RAS_HIGH_LSB];
                `RAS_OFF_TOS_UPPER:
                    rdata <= {`RAS_PAD3_ZERO, top_entry[`RAS_UPPER_MSB:`RAS_UPPER_LSB]};
                default:
                    rdata <= `RAS_BYTE_ZERO;
            endcase
        end
        else
            rdata <= `RAS_BYTE_ZERO;
    end

    property p_push_inc;
        @(posedge clock) disable iff (!rst_n)
        (do_push && ptr_r < `RAS_PTR_MAX - `RAS_PTR_ONE && state_r != ras_pkg::ST_RESET)
            |=> ptr_r == $past(ptr_r) + `RAS_PTR_ONE;
    endproperty
    a_push_inc: assert property (p_push_inc) else $error("push did not increment");

    property p_pop_dec;
        @(posedge clock) disable iff (!rst_n)
        (do_pop && !at_empty && state_r != ras_pkg::ST_RESET)
            |=> ptr_r == $past(ptr_r) - `RAS_PTR_ONE;
    endproperty
    a_pop_dec: assert property (p_pop_dec) else $error("pop did not decrement");

    property p_full_set;
        @(posedge clock) disable iff (!rst_n || !por_n)
        full_event |=> stack_full_flag;
    endproperty
    a_full_set: assert property (p_full_set) else $error("full flag not set");

    property p_full_hold;
        @(posedge clock) disable iff (!rst_n || !por_n)
        (stack_full_flag && !reg_wr_ptr) |=> stack_full_flag;
    endproperty
    a_full_hold: assert property (p_full_hold) else $error("full flag dropped");

    property p_stay_max;
        @(posedge clock) disable iff (!rst_n)
        (at_full && do_push && !overflow_reset_enable && state_r != ras_pkg::ST_RESET)
            |=> at_full;
    endproperty
    a_stay_max: assert property (p_stay_max) else $error("pointer left 31");

    property p_unf;
        @(posedge clock) disable iff (!rst_n || !por_n)
        unf_event |=> stack_underflow_flag && at_empty && pop_value == `RAS_PC_ZERO;
    endproperty
    a_unf: assert property (p_unf) else $error("underflow handling wrong");

    property p_ovr_reset;
        @(posedge clock) disable iff (!rst_n)
        (overflow_reset_enable && full_event && state_r == ras_pkg::ST_RUN)
            |=> stack_reset_req ##1 at_empty;
    endproperty
    a_ovr_reset: assert property (p_ovr_reset) else $error("no overflow reset");

    property p_no_reset_off;
        @(posedge clock) disable iff (!rst_n)
        (!overflow_reset_enable && (full_event || unf_event)) |=> !stack_reset_req;
    endproperty
    a_no_reset_off: assert property (p_no_reset_off) else $error("reset while disabled");

    property p_bit5;
        @(posedge clock) disable iff (!rst_n)
        (bus.rd && bus.addr == `RAS_OFF_PTR) |=> rdata[5] == 1'b0 && rdata[4:0] == $past(ptr_r);
    endproperty
    a_bit5: assert property (p_bit5) else $error("pointer read wrong");

    property p_unf_hold;
        @(posedge clock) disable iff (!rst_n || !por_n)
        (stack_underflow_flag && !reg_wr_ptr) |=> stack_underflow_flag;
    endproperty
    a_unf_hold: assert property (p_unf_hold) else $error("underflow flag dropped");

    property p_no_sw_set;
        @(posedge clock) disable iff (!rst_n || !por_n)
        (!stack_full_flag && !full_event && !(do_push && at_full)) |=> !stack_full_flag;
    endproperty
    a_no_sw_set: assert property (p_no_sw_set) else $error("full flag set by write");

    property p_reset_ptr;
        @(posedge clock)
        !rst_n |=> at_empty;
    endproperty
    a_reset_ptr: assert property (p_reset_ptr) else $error("pointer not cleared");

    property p_full_keep;
        @(posedge clock) disable iff (!rst_n)
        (do_push && at_full) |-> !mem_we;
    endproperty
    a_full_keep: assert property (p_full_keep) else $error("top overwritten");

    property p_top_zero;
        @(posedge clock) disable iff (!rst_n)
        (bus.rd && bus.addr != `RAS_OFF_PTR && at_empty) |=> rdata == `RAS_BYTE_ZERO;
    endproperty
    a_top_zero: assert property (p_top_zero) else $error("top read not zero");

    property p_pop_pulse;
        @(posedge clock) disable iff (!rst_n)
        do_pop |=> pop_valid && pop_value == $past(top_entry);
    endproperty
    a_pop_pulse: assert property (p_pop_pulse) else $error("pop value wrong");

    property p_restore;
        @(posedge clock) disable iff (!rst_n)
        shadow_restore |=> restore_valid;
    endproperty
    a_restore: assert property (p_restore) else $error("restore not flagged");

    c_full:  cover property (@(posedge clock) disable iff (!rst_n) full_event);
    c_unf:   cover property (@(posedge clock) disable iff (!rst_n) unf_event);
    c_reset: cover property (@(posedge clock) disable iff (!rst_n) stack_reset_req);
    c_rest:  cover property (@(posedge clock) disable iff (!rst_n) restore_valid);
endmodule : return_address_stack

// [testbench/ras_sequencer_model.sv]
// sequencer stand-in: one-cycle push/pop and shadow save/restore requests
// assumes the bench calls its tasks from one thread only
`timescale 1ns/1ps
`include "ras_params.svh"
module ras_sequencer_model
(
    input  wire logic                 clock,
    output      logic                 push,
    output      logic                 pop,
    output      logic                 push_plus_two,
    output      logic [`RAS_PC_W-1:0] program_counter,
    output      logic                 shadow_save,
    output      logic                 shadow_restore,
    output      ras_pkg::core_regs_t  live_regs
);
    initial
    begin
        push = 1'b0;
        pop = 1'b0;
        push_plus_two = 1'b0;
        program_counter = 21'h000000;
        shadow_save = 1'b0;
        shadow_restore = 1'b0;
        live_regs = 24'h000000;
    end

    // calls and interrupts push, returns pop; on release push/pop drop, the other lines show inverse
    task automatic stack_op(input logic ps, input logic pp, input logic p2,
                            input logic [`RAS_PC_W-1:0] pc);
        @(posedge clock);
        push <= ps;
        pop <= pp;
        push_plus_two <= p2;
        program_counter <= pc;
        @(posedge clock);
        push <= 1'b0;
        pop <= 1'b0;
        push_plus_two <= ~p2;
        program_counter <= ~pc;
    endtask : stack_op

    // interrupt vector or fast call saves, fast return restores
    task automatic shadow_op(input logic sv, input logic rs,
                             input ras_pkg::core_regs_t r);
        @(posedge clock);
        shadow_save <= sv;
        shadow_restore <= rs;
        live_regs <= r;
        @(posedge clock);
        shadow_save <= 1'b0;
        shadow_restore <= 1'b0;
        live_regs <= ~r;
    endtask : shadow_op
endmodule : ras_sequencer_model

// [testbench/return_address_stack_bench.sv]
// self-checking bench for the return address stack
// assumes ras_sequencer_model drives the stack side, bench drives the register port
`timescale 1ns/1ps
`include "ras_params.svh"
module return_address_stack_bench;
    logic                 clock;
    logic                 rst_n;
    logic                 por_n;
    logic                 ovf_en;
    ras_pkg::reg_req_t    bus;
    logic                 push;
    logic                 pop;
    logic                 plus2;
    logic [20:0]          pc;
    logic                 sv;
    logic                 rs;
    ras_pkg::core_regs_t  live;
    logic [7:0]           rdata;
    logic [20:0]          pop_value;
    logic                 pop_valid;
    logic                 rst_req;
    ras_pkg::core_regs_t  rest;
    logic                 rest_v;
    logic                 rd_d;
    int                   failures;
    int                   checks_done;
    int                   rst_due;
    logic [23:0]          q_rd[$];
    logic [23:0]          q_pop[$];
    logic [23:0]          q_rest[$];
    logic [20:0]          mem[1:31];
    logic [4:0]           ptr;
    logic                 full;
    logic                 unf;
    logic [23:0]          shadow;

    always #5 clock = ~clock;

    ras_sequencer_model i_seq (.clock(clock), .push(push), .pop(pop), .push_plus_two(plus2),
        .program_counter(pc), .shadow_save(sv), .shadow_restore(rs), .live_regs(live));

    return_address_stack i_dut (.clock(clock), .rst_n(rst_n), .por_n(por_n),
        .overflow_reset_enable(ovf_en), .push(push), .pop(pop), .push_plus_two(plus2),
        .program_counter(pc), .shadow_save(sv), .shadow_restore(rs), .live_regs(live),
        .bus(bus), .rdata(rdata), .pop_value(pop_value), .pop_valid(pop_valid),
        .stack_reset_req(rst_req), .restore_regs(rest), .restore_valid(rest_v));

    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic final_report;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report

    // result watcher: oldest note against what the outputs show
    always @(posedge clock) rd_d <= bus.rd;
    always @(negedge clock)
    begin
        if (rd_d === 1'b1)
            check("rdata", {16'h0000, rdata}, q_rd.size() ? q_rd.pop_front() : 24'hXXXXXX);
        else
            check("rdata idle", {16'h0000, rdata}, 24'h000000);
        if (pop_valid === 1'b1)
            check("pop", {3'h0, pop_value}, q_pop.size() ? q_pop.pop_front() : 24'hXXXXXX);
        if (rest_v === 1'b1)
            check("restore", rest, q_rest.size() ? q_rest.pop_front() : 24'hXXXXXX);
        if (rst_req === 1'b1)
        begin
            check("reset req", {23'h0, rst_due > 0}, 24'h000001);
            rst_due--;
        end
    end

    task automatic bus_op(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
        @(posedge clock);
        bus <= '{addr: a, wdata: d, wr: w, rd: r};
        @(posedge clock);
        bus <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask : bus_op

    task automatic rd_exp(input logic [3:0] a);
        logic [20:0] t;
        t = (ptr == 5'h00) ? 21'h000000 : mem[ptr];
        case (a)
            4'h0: q_rd.push_back({16'h0000, full, unf, 1'b0, ptr});
            4'h1: q_rd.push_back({16'h0000, t[7:0]});
            4'h2: q_rd.push_back({16'h0000, t[15:8]});
            4'h3: q_rd.push_back({19'h00000, t[20:16]});
            default: q_rd.push_back(24'h000000);
        endcase
        bus_op(1'b0, 1'b1, a, 8'h00);
    endtask : rd_exp

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        if (a == 4'h0)
        begin
            ptr = d[4:0];
            full = full & d[7];
            unf = unf & d[6];
        end
        else if (ptr != 5'h00 && a == 4'h1)
            mem[ptr][7:0] = d;
        else if (ptr != 5'h00 && a == 4'h2)
            mem[ptr][15:8] = d;
        else if (ptr != 5'h00 && a == 4'h3)
            mem[ptr][20:16] = d[4:0];
        bus_op(1'b1, 1'b0, a, d);
    endtask : wr_reg

    task automatic sop(input logic ps, input logic pp, input logic p2, input logic [20:0] v);
        if (pp)
        begin
            q_pop.push_back({3'h0, (ptr == 5'h00) ? 21'h000000 : mem[ptr]});
            if (ptr == 5'h00)
            begin
                unf = 1'b1;
                rst_due += ovf_en;
            end
            else
                ptr--;
        end
        else if (ps && ptr == 5'h1F)
            full = 1'b1;
        else if (ps)
        begin
            ptr++;
            mem[ptr] = p2 ? v + 21'h000002 : v;
            if (ptr == 5'h1F)
            begin
                full = 1'b1;
                rst_due += ovf_en;
                ptr = ovf_en ? 5'h00 : ptr;
            end
        end
        i_seq.stack_op(ps, pp, p2, v);
    endtask : sop

    task automatic shd(input logic s, input logic r, input logic [23:0] v);
        if (s)
            shadow = v;
        if (r)
            q_rest.push_back(shadow);
        i_seq.shadow_op(s, r, v);
    endtask : shd

    initial
    begin
        repeat (20000) @(posedge clock);
        failures++;
        final_report();
    end

    initial
    begin
        clock = 1'b0;
        rst_n = 1'b0;
        por_n = 1'b0;
        ovf_en = 1'b0;
        bus = '0;
        {failures, checks_done, rst_due} = '0;
        {ptr, full, unf, shadow} = '0;
        void'($urandom(80767));
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        for (int a = 0; a < 16; a++) rd_exp(a[3:0]);
        wr_reg(4'h1, 8'hA5);
        rd_exp(4'h1);
        shd(1'b1, 1'b0, 24'($urandom()));
        for (int i = 0; i < 31; i++)
        begin
            sop(1'b1, 1'b0, i[0], 21'($urandom()));
            rd_exp(4'h0);
        end
        sop(1'b1, 1'b0, 1'b0, 21'($urandom()));
        for (int a = 0; a < 4; a++) rd_exp(a[3:0]);
        for (int a = 1; a < 4; a++) wr_reg(a[3:0], 8'($urandom()));
        for (int a = 0; a < 4; a++) rd_exp(a[3:0]);
        for (int i = 0; i < 32; i++) sop(1'b0, 1'b1, 1'b0, 21'h000000);
        rd_exp(4'h0);
        shd(1'b0, 1'b1, 24'h000000);
        wr_reg(4'h0, 8'hE5);
        rd_exp(4'h0);
        wr_reg(4'h0, 8'h00);
        wr_reg(4'h0, 8'hC0);
        rd_exp(4'h0);
        shd(1'b1, 1'b0, 24'($urandom()));
        shd(1'b1, 1'b0, 24'($urandom()));
        shd(1'b0, 1'b1, 24'h000000);
        sop(1'b1, 1'b0, 1'b0, 21'($urandom()));
        sop(1'b1, 1'b0, 1'b0, 21'($urandom()));
        sop(1'b0, 1'b1, 1'b0, 21'h000000);
        for (int a = 1; a < 4; a++) rd_exp(a[3:0]);
        sop(1'b1, 1'b1, 1'b0, 21'($urandom()));
        sop(1'b0, 1'b1, 1'b0, 21'h000000);
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        ptr = 5'h00;
        rd_exp(4'h0);
        ovf_en <= 1'b1;
        wr_reg(4'h0, 8'h1E);
        sop(1'b1, 1'b0, 1'b1, 21'($urandom()));
        repeat (3) @(posedge clock);
        rd_exp(4'h0);
        wr_reg(4'h0, 8'h9F);
        for (int a = 1; a < 4; a++) rd_exp(a[3:0]);
        wr_reg(4'h0, 8'h00);
        sop(1'b0, 1'b1, 1'b0, 21'h000000);
        repeat (3) @(posedge clock);
        rd_exp(4'h0);
        rst_n <= 1'b0;
        por_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        {ptr, full, unf} = '0;
        rd_exp(4'h0);
        for (int i = 0; i < 20 && (q_rd.size() || q_pop.size() || q_rest.size()); i++)
            @(posedge clock);
        if (q_rd.size() || q_pop.size() || q_rest.size() || rst_due != 0)
            failures++;
        final_report();
    end
endmodule : return_address_stack_bench
